// file: core/mhq_core.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Operation
// - Capture count accepted from 0 to 200
// - Out-of-range count clamps, no error
// - Sample order: pos/vel axes 1-4, then I/O
// - Samples back to back, one per 2.3 ms
// - Return queue holds 200 full samples
// - Data replies during capture interleave samples
// - Store open takes buffer index 1 to 4
// - Open session records functions, never executes
// - Trigger input or software trigger replays buffer
// - Buffer sizes per servo/stepper board table
// - Buffer two may overrun three, unchecked
// - Store open while open raises function error
// - Direct control suspended during store session
// - Capacity counted in whole function packets
// - Modes: send, send and read, read only
// - Packet data at most two 16-bit words
// - Mode 0 queues reply, mode 1 returns directly
// - Read-only mode pops head of queue
// - Queue is FIFO, emptied by reads or flush
module mhq_core
   import mhq_pkg::*;
#(
   parameter logic [TMR_W-1:0] SAMPLE_CYC = TMR_W'(SAMPLE_PERIOD_CYC),
   parameter bit BOARD_STEPPER = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] trig_pin,
   input wire mhq_smp_t smp_in,
   input wire logic [31:0] reply_data,
   output logic exec_valid,
   output mhq_pkt_t exec_pkt
);

   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;
   logic [7:0] cmd_axis_r, cmd_func_r;
   logic [1:0] cmd_mode_r;
   logic [3:0] cmd_wcnt_r;
   logic [31:0] data_r;
   logic [3:0] trig_en_r, trig_s1_r, trig_s2_r, trig_d_r;
   logic ovf_r, ferr_r, store_open_r;
   logic [1:0] st_sel_r;
   logic [11:0] st_cnt_r [4];
   logic rp_busy_r;
   logic [1:0] rp_sel_r;
   logic [11:0] rp_idx_r;
   logic [RQ_AW-1:0] q_wp_r, q_rp_r;
   logic [11:0] q_cnt_r;
   mhq_pkt_t rply_r;
   logic rply_vld_r;
   mhq_cap_t cap_st_r;
   logic [7:0] cap_left_r;
   logic [TMR_W-1:0] cap_tmr_r;
   logic [3:0] cap_w_r;
   mhq_smp_t smp_r;
   logic exec_valid_r;
   mhq_pkt_t exec_pkt_r;
   mhq_pkt_t rq_mem [RQ_DEPTH];
   mhq_pkt_t tb_mem [TB_DEPTH];

   // APB decode; one wait state so read data leaves a flop
   wire apb_acc = psel & penable;
   wire rd_prep = apb_acc & ~pready_r;
   wire wr_go = apb_acc & pready_r & pwrite;
   wire hit_cmd = paddr == ADDR_CMD;
   wire hit_data = paddr == ADDR_DATA;
   wire hit_head = paddr == ADDR_RPLY_HEAD;
   wire hit_rdat = paddr == ADDR_RPLY_DATA;
   wire hit_stat = paddr == ADDR_STATUS;
   wire hit_trig = paddr == ADDR_TRIG_EN;
   wire addr_ok = hit_cmd | hit_data | hit_head | hit_rdat | hit_stat | hit_trig;
   wire host_go = wr_go & hit_cmd;
   wire [1:0] host_mode = pwdata[CMD_MODE_LSB +: 2];
   wire host_pop = host_go & (host_mode == MODE_READ);
   wire host_fn = host_go & (host_mode != MODE_READ);

   // Queue state
   wire q_empty = q_cnt_r == 12'h000;
   wire q_full = q_cnt_r == RQ_FULL_CNT;

   // Dispatch: host function wins, replay waits a cycle
   wire [11:0] rp_end = st_cnt_r[rp_sel_r];
   wire rp_valid = rp_busy_r & (rp_idx_r != rp_end);
   wire rp_step = rp_valid & ~host_fn;
   wire [TB_AW-1:0] rp_addr = TB_AW'(tb_base(rp_sel_r, BOARD_STEPPER) + 13'(rp_idx_r));
   mhq_pkt_t host_pkt, dsp_pkt;
   assign host_pkt = '{axis: pwdata[CMD_AXIS_LSB +: 8], func: pwdata[CMD_FUNC_LSB +: 8],
                       data: data_r};
   assign dsp_pkt = host_fn ? host_pkt : tb_mem[rp_addr];
   wire dsp_valid = host_fn | rp_step;
   wire [1:0] dsp_mode = host_fn ? host_mode : MODE_SEND;
   wire [7:0] dfn = dsp_pkt.func;

   // Function decode
   wire is_open = dsp_valid & (dfn == FN_STORE_OPEN);
   wire is_close = dsp_valid & (dfn == FN_STORE_CLOSE);
   wire idx_ok = (dsp_pkt.data >= TB_IDX_MIN) & (dsp_pkt.data <= TB_IDX_MAX);
   wire [1:0] idx_sel = dsp_pkt.data[1:0] - 2'h1;
   wire open_ok = is_open & ~store_open_r & idx_ok;
   wire open_err = is_open & (store_open_r | ~idx_ok);
   wire store_rec = dsp_valid & store_open_r & ~is_open & ~is_close;
   wire d_live = dsp_valid & ~store_open_r & ~is_open & ~is_close;
   wire live_acq = d_live & (dfn == FN_ACQUIRE);
   wire live_trig = d_live & (dfn == FN_SW_TRIG);
   wire live_flush = d_live & (dfn == FN_FLUSH);
   wire live_user = d_live & ~live_acq & ~live_trig & ~live_flush;
   wire user_req = live_user & dfn[FN_REQ_BIT];
   wire reply_direct = user_req & (dsp_mode == MODE_SEND_READ);
   wire push_fn = user_req & (dsp_mode != MODE_SEND_READ);

   // Recording: no check that buffer two stays out of three
   wire [11:0] st_cur = st_cnt_r[st_sel_r];
   wire st_room = st_cur < tb_cap(st_sel_r, BOARD_STEPPER);
   wire [TB_AW-1:0] st_addr = TB_AW'(tb_base(st_sel_r, BOARD_STEPPER) + 13'(st_cur));

   // Trigger inputs: two flops, then edge detect on the second
   wire [3:0] hw_rise = trig_s2_r & ~trig_d_r & trig_en_r;
   wire [1:0] hw_sel = hw_rise[0] ? 2'h0 : hw_rise[1] ? 2'h1 : hw_rise[2] ? 2'h2 : 2'h3;
   wire sw_ok = live_trig & idx_ok;
   wire rp_start = ~rp_busy_r & ~store_open_r & (sw_ok | (|hw_rise));
   wire [1:0] rp_sel_nxt = sw_ok ? idx_sel : hw_sel;

   // Capture sequencer signals
   wire [7:0] cap_req = (dsp_pkt.data > 32'(CAP_MAX)) ? CAP_MAX : dsp_pkt.data[7:0];
   wire cap_emit = cap_st_r == CAP_EMIT;
   wire cap_adv = cap_emit & ~push_fn;
   wire cap_last_w = cap_w_r == SMP_LAST_WORD;
   wire [1:0] cap_ax = cap_w_r[2:1];
   mhq_pkt_t cap_pkt;
   assign cap_pkt = '{axis: cap_last_w ? 8'h00 : {6'h00, cap_ax} + 8'h01, func: FN_ACQUIRE,
                      data: cap_last_w ? smp_r.io
                          : cap_w_r[0] ? smp_r.vel[cap_ax] : smp_r.pos[cap_ax]};

   // Queue push selection; a flush in the same cycle drops the sample word
   wire q_push = (push_fn | cap_adv) & ~live_flush;
   mhq_pkt_t q_din;
   assign q_din = push_fn ? '{axis: dsp_pkt.axis, func: dsp_pkt.func, data: reply_data}
                          : cap_pkt;
   wire push_ok = q_push & ~q_full;
   wire pop_ok = host_pop & ~q_empty;
   wire ovf_set = q_push & q_full;

   // Status word and read mux
   wire [31:0] status_w = {4'h0, q_cnt_r, 9'h000, rp_busy_r, cap_st_r != CAP_IDLE,
                           store_open_r, ferr_r, ovf_r, q_full, q_empty};
   wire [31:0] rd_mux = hit_cmd ? {8'h00, cmd_wcnt_r, 2'h0, cmd_mode_r, cmd_func_r, cmd_axis_r}
                      : hit_data ? data_r
                      : hit_head ? {rply_vld_r, 15'h0000, rply_r.func, rply_r.axis}
                      : hit_rdat ? rply_r.data
                      : hit_stat ? status_w
                      : hit_trig ? {28'h0000000, trig_en_r}
                      : 32'h0000_0000;
   wire w1c_go = wr_go & hit_stat;

   // APB slave registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= rd_prep;
         pslverr_r <= rd_prep & ~addr_ok;
         prdata_r <= rd_prep ? rd_mux : prdata_r;
      end
   end

   // Software-written settings; word count is kept for readback only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_axis_r <= 8'h00;
         cmd_func_r <= 8'h00;
         cmd_mode_r <= 2'h0;
         cmd_wcnt_r <= 4'h0;
         data_r <= 32'h0000_0000;
         trig_en_r <= 4'h0;
      end else begin
         if (host_go) begin
            cmd_axis_r <= pwdata[CMD_AXIS_LSB +: 8];
            cmd_func_r <= pwdata[CMD_FUNC_LSB +: 8];
            cmd_mode_r <= host_mode;
            cmd_wcnt_r <= pwdata[CMD_WCNT_LSB +: 4];
         end
         if (wr_go & hit_data)
            data_r <= pwdata;
         if (wr_go & hit_trig)
            trig_en_r <= pwdata[3:0];
      end
   end

   // Sticky flags: a set in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_r <= 1'b0;
         ferr_r <= 1'b0;
      end else begin
         ovf_r <= ovf_set | (ovf_r & ~(w1c_go & pwdata[ST_OVF]));
         ferr_r <= open_err | (ferr_r & ~(w1c_go & pwdata[ST_FERR]));
      end
   end

   // Store session and per-buffer packet counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         store_open_r <= 1'b0;
         st_sel_r <= 2'h0;
         for (int i = 0; i < 4; i++)
            st_cnt_r[i] <= 12'h000;
      end else begin
         if (open_ok) begin
            store_open_r <= 1'b1;
            st_sel_r <= idx_sel;
            st_cnt_r[idx_sel] <= 12'h000;
         end else if (is_close)
            store_open_r <= 1'b0;
         if (store_rec & st_room)
            st_cnt_r[st_sel_r] <= st_cur + 12'h001;
      end
   end

   // Trigger buffer storage; contents are undefined until recorded
   always_ff @(posedge pclk) begin
      if (store_rec & st_room)
         tb_mem[st_addr] <= dsp_pkt;
   end

   // Trigger synchronisers and replay walker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_s1_r <= 4'h0;
         trig_s2_r <= 4'h0;
         trig_d_r <= 4'h0;
         rp_busy_r <= 1'b0;
         rp_sel_r <= 2'h0;
         rp_idx_r <= 12'h000;
      end else begin
         trig_s1_r <= trig_pin;
         trig_s2_r <= trig_s1_r;
         trig_d_r <= trig_s2_r;
         if (rp_start) begin
            rp_busy_r <= 1'b1;
            rp_sel_r <= rp_sel_nxt;
            rp_idx_r <= 12'h000;
         end else if (rp_busy_r & ~rp_valid)
            rp_busy_r <= 1'b0;
         else if (rp_step)
            rp_idx_r <= rp_idx_r + 12'h001;
      end
   end

   // Capture sequencer: nine words per sample, period from sample start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_st_r <= CAP_IDLE;
         cap_left_r <= 8'h00;
         cap_tmr_r <= '0;
         cap_w_r <= 4'h0;
         smp_r <= '0;
      end else if (live_acq) begin
         cap_left_r <= cap_req;
         cap_tmr_r <= '0;
         cap_w_r <= 4'h0;
         cap_st_r <= (cap_req == 8'h00) ? CAP_IDLE : CAP_WAIT;
      end else begin
         case (cap_st_r)
            CAP_IDLE: cap_tmr_r <= '0;
            CAP_WAIT: begin
               if (cap_tmr_r == '0) begin
                  smp_r <= smp_in;
                  cap_w_r <= 4'h0;
                  cap_tmr_r <= SAMPLE_CYC - TMR_W'(1);
                  cap_st_r <= CAP_EMIT;
               end else
                  cap_tmr_r <= cap_tmr_r - TMR_W'(1);
            end
            CAP_EMIT: begin
               cap_tmr_r <= cap_tmr_r - TMR_W'(1);
               if (cap_adv & cap_last_w) begin
                  cap_left_r <= cap_left_r - 8'h01;
                  cap_st_r <= (cap_left_r == 8'h01) ? CAP_IDLE : CAP_WAIT;
               end else if (cap_adv)
                  cap_w_r <= cap_w_r + 4'h1;
            end
            default: cap_st_r <= CAP_IDLE;
         endcase
      end
   end

   // Return queue pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_wp_r <= '0;
         q_rp_r <= '0;
         q_cnt_r <= 12'h000;
      end else if (live_flush) begin
         q_wp_r <= '0;
         q_rp_r <= '0;
         q_cnt_r <= 12'h000;
      end else begin
         if (push_ok)
            q_wp_r <= q_wp_r + RQ_AW'(1);
         if (pop_ok)
            q_rp_r <= q_rp_r + RQ_AW'(1);
         q_cnt_r <= q_cnt_r + 12'(push_ok) - 12'(pop_ok);
      end
   end

   // Queue storage
   always_ff @(posedge pclk) begin
      if (push_ok)
         rq_mem[q_wp_r] <= q_din;
   end

   // Reply registers: direct answer or queue head
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rply_r <= '0;
         rply_vld_r <= 1'b0;
      end else if (reply_direct & host_fn) begin
         rply_r <= '{axis: dsp_pkt.axis, func: dsp_pkt.func, data: reply_data};
         rply_vld_r <= 1'b1;
      end else if (host_fn & (host_mode == MODE_SEND_READ))
         rply_vld_r <= 1'b0;
      else if (host_pop) begin
         rply_r <= q_empty ? '0 : rq_mem[q_rp_r];
         rply_vld_r <= ~q_empty;
      end
   end

   // Execution port toward the motion core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_valid_r <= 1'b0;
         exec_pkt_r <= '0;
      end else begin
         exec_valid_r <= live_user;
         exec_pkt_r <= dsp_pkt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign exec_valid = exec_valid_r;
   assign exec_pkt = exec_pkt_r;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_cap_clamp: assert property (live_acq & (dsp_pkt.data > 32'(CAP_MAX)) |=>
      cap_left_r == CAP_MAX) else $error("capture count not clamped");
   chk_cap_range: assert property (cap_left_r <= CAP_MAX)
      else $error("capture count above limit");
   chk_smp_gapless: assert property (cap_adv & ~cap_last_w & ~live_acq |=>
      cap_emit && cap_w_r == $past(cap_w_r) + 4'h1) else $error("sample words not back to back");
   chk_smp_order: assert property (cap_adv & ~push_fn & (cap_w_r == 4'h1) |->
      q_din.axis == 8'h01 && q_din.data == smp_r.vel[0]) else $error("sample word order wrong");
   chk_store_noexec: assert property (store_open_r & dsp_valid |=> !exec_valid_r)
      else $error("function executed during store session");
   chk_reopen_err: assert property (is_open & store_open_r |=> ferr_r & store_open_r)
      else $error("reopen did not raise function error");
   chk_ovf_drop: assert property (ovf_set & ~pop_ok & ~live_flush |=>
      ovf_r && q_cnt_r == $past(q_cnt_r)) else $error("overflow not dropped or flagged");
   chk_direct_reply: assert property (reply_direct & host_fn |=>
      rply_vld_r && q_cnt_r == $past(q_cnt_r) - 12'($past(pop_ok))) else $error("mode 1 queued");
   chk_flush_empty: assert property (live_flush |=> q_empty)
      else $error("flush left queue non-empty");
   chk_period: assert property ($rose(cap_emit) |-> ##1 !$rose(cap_emit) [*8])
      else $error("sample started too early");

endmodule

// file: core/mhq_pkg.sv
package mhq_pkg;
   // Board clock and capture timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SAMPLE_PERIOD_NS = 2300000;
   localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TMR_W = 19;
   localparam logic [7:0] CAP_MAX = 8'hC8;
   localparam logic [3:0] SMP_LAST_WORD = 4'h8;

   // Return queue and trigger buffer storage
   localparam int RQ_AW = 11;
   localparam int RQ_DEPTH = 2048;
   localparam logic [11:0] RQ_FULL_CNT = 12'h800;
   localparam int TB_AW = 13;
   localparam int TB_DEPTH = 5120;
   localparam logic [31:0] TB_IDX_MIN = 32'h0000_0001;
   localparam logic [31:0] TB_IDX_MAX = 32'h0000_0004;

   // Register byte offsets
   localparam logic [11:0] ADDR_CMD = 12'h000;
   localparam logic [11:0] ADDR_DATA = 12'h004;
   localparam logic [11:0] ADDR_RPLY_HEAD = 12'h008;
   localparam logic [11:0] ADDR_RPLY_DATA = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam logic [11:0] ADDR_TRIG_EN = 12'h014;

   // Field positions
   localparam int CMD_AXIS_LSB = 0;
   localparam int CMD_FUNC_LSB = 8;
   localparam int CMD_MODE_LSB = 16;
   localparam int CMD_WCNT_LSB = 20;
   localparam int RPLY_VLD_BIT = 31;
   localparam int ST_EMPTY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_OVF = 2;
   localparam int ST_FERR = 3;
   localparam int ST_STORE = 4;
   localparam int ST_CAP = 5;
   localparam int ST_REPLAY = 6;
   localparam int ST_CNT_LSB = 16;
   localparam int FN_REQ_BIT = 7;

   // Function codes handled inside the block
   localparam logic [7:0] FN_ACQUIRE = 8'h01;
   localparam logic [7:0] FN_STORE_OPEN = 8'h02;
   localparam logic [7:0] FN_STORE_CLOSE = 8'h03;
   localparam logic [7:0] FN_SW_TRIG = 8'h04;
   localparam logic [7:0] FN_FLUSH = 8'h05;

   typedef enum logic [1:0] {
      MODE_SEND = 2'b00,
      MODE_SEND_READ = 2'b01,
      MODE_READ = 2'b10
   } mhq_mode_t;

   typedef enum logic [1:0] {
      CAP_IDLE = 2'b00,
      CAP_WAIT = 2'b01,
      CAP_EMIT = 2'b10
   } mhq_cap_t;

   typedef struct packed {
      logic [7:0] axis;
      logic [7:0] func;
      logic [31:0] data;
   } mhq_pkt_t;

   typedef struct packed {
      logic [3:0][31:0] pos;
      logic [3:0][31:0] vel;
      logic [31:0] io;
   } mhq_smp_t;

   // Trigger buffer placement; buffer two runs on into buffer three
   function automatic logic [12:0] tb_base(input logic [1:0] sel, input logic stepper);
      case (sel)
         2'h0: tb_base = 13'h0000;
         2'h1: tb_base = stepper ? 13'h0280 : 13'h0400;
         2'h2: tb_base = stepper ? 13'h0500 : 13'h0800;
         default: tb_base = stepper ? 13'h0780 : 13'h0C00;
      endcase
   endfunction

   function automatic logic [11:0] tb_cap(input logic [1:0] sel, input logic stepper);
      case (sel)
         2'h0, 2'h2: tb_cap = stepper ? 12'h280 : 12'h400;
         default: tb_cap = stepper ? 12'h500 : 12'h800;
      endcase
   endfunction
endpackage

// file: tb/mhq_motion_model.sv
`timescale 1ns/1ps
// Stand-in for the motion core that sits behind the command queue
module mhq_motion_model
   import mhq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic exec_valid,
   input wire mhq_pkt_t exec_pkt,
   output mhq_smp_t smp_in,
   output logic [31:0] reply_data,
   output logic [15:0] exec_cnt,
   output mhq_pkt_t last_pkt
);
   // Each axis gets its own value so that a slip in word order shows
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         smp_in.pos[k] = 32'h1000_0000 + k;
         smp_in.vel[k] = 32'h2000_0000 + k;
      end
      smp_in.io = 32'h0000_00A5;
   end

   // Reply stays within two 16-bit data words
   assign reply_data = 32'h0000_1234;

   // Count executed functions and keep the last one for the bench
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_cnt <= 16'h0000;
         last_pkt <= '0;
      end else if (exec_valid) begin
         exec_cnt <= exec_cnt + 16'h0001;
         last_pkt <= exec_pkt;
      end
   end
endmodule

// file: tb/motion_host_command_queue_tb.sv
`timescale 1ns/1ps
module motion_host_command_queue_tb
   import mhq_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, reply_data, v;
   logic [3:0] trig_pin;
   logic [15:0] exec_cnt;
   mhq_smp_t smp_in;
   mhq_pkt_t exec_pkt, last_pkt;
   int failures = 0;
   int tests_run = 0;

   // Short sample period keeps a full 200-sample capture inside the run
   mhq_core #(.SAMPLE_CYC(19'd20), .BOARD_STEPPER(1'b0)) mhq_core_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin), .smp_in(smp_in),
      .reply_data(reply_data), .exec_valid(exec_valid), .exec_pkt(exec_pkt));
   mhq_motion_model mhq_motion_model_i (
      .pclk(pclk), .presetn(presetn), .exec_valid(exec_valid), .exec_pkt(exec_pkt),
      .smp_in(smp_in), .reply_data(reply_data), .exec_cnt(exec_cnt),
      .last_pkt(last_pkt));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, exp);
   endtask

   // Data first, then the command word that launches; wcount is 2 plus data words
   task fn(input logic [1:0] mode, input logic [7:0] ax, input logic [7:0] f,
           input logic [31:0] d);
      wr(ADDR_DATA, d);
      wr(ADDR_CMD, {8'h00, 4'h4, 2'b00, mode, f, ax});
   endtask

   task pop(input logic [31:0] head, input logic [31:0] data);
      fn(MODE_READ, 8'h00, 8'h00, 32'h0);
      rd_chk("reply head", ADDR_RPLY_HEAD, head);
      rd_chk("reply data", ADDR_RPLY_DATA, data);
   endtask

   // Poll until the capture is over; host waits well past the sample time
   task cap_wait();
      int n;
      logic e;
      n = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0, v, e);
         n++;
      end while (v[ST_CAP] !== 1'b0 && n < 3000);
      if (n >= 3000) begin
         failures++;
         give_verdict();
      end
   endtask

   task exec_wait(input logic [15:0] n_exp);
      int n;
      n = 0;
      while (exec_cnt !== n_exp && n < 20) begin
         @(posedge pclk);
         n++;
      end
      // A replay that never shows up is a failure, not a silent pass
      if (n >= 20) begin
         failures++;
         give_verdict();
      end
   endtask

   initial begin
      logic e;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      trig_pin = 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset state and refused access
      rd_chk("status reset", ADDR_STATUS, 32'h0000_0001);
      rd_chk("trig enable reset", ADDR_TRIG_EN, 32'h0000_0000);
      apb(1'b0, 12'h020, 32'h0, v, e);
      check("unmapped err", e, 1'b1);
      check("unmapped data", v, 32'h0);
      $display("test reset done");
      // Three exchange modes and queue order
      fn(MODE_SEND, 8'h02, 8'h10, 32'h0000_0055);
      exec_wait(16'h0001);
      check("exec pkt", last_pkt, {8'h02, 8'h10, 32'h0000_0055});
      fn(MODE_SEND, 8'h01, 8'h90, 32'h0);
      fn(MODE_SEND, 8'h03, 8'h91, 32'h0);
      rd_chk("queued two", ADDR_STATUS, 32'h0002_0000);
      pop(32'h8000_9001, 32'h0000_1234);
      pop(32'h8000_9103, 32'h0000_1234);
      pop(32'h0000_0000, 32'h0000_0000);
      fn(MODE_SEND_READ, 8'h04, 8'h92, 32'h0);
      rd_chk("direct head", ADDR_RPLY_HEAD, 32'h8000_9204);
      rd_chk("nothing queued", ADDR_STATUS, 32'h0000_0001);
      $display("test modes done");
      // Capture: order, zero count, interleave, clamp and overflow
      fn(MODE_SEND, 8'h00, FN_ACQUIRE, 32'h0000_0001);
      cap_wait();
      rd_chk("one sample", ADDR_STATUS, 32'h0009_0000);
      for (int k = 0; k < 4; k++) begin
         pop(32'h8000_0101 + k, 32'h1000_0000 + k);
         pop(32'h8000_0101 + k, 32'h2000_0000 + k);
      end
      pop(32'h8000_0100, 32'h0000_00A5);
      fn(MODE_SEND, 8'h00, FN_ACQUIRE, 32'h0000_0000);
      cap_wait();
      rd_chk("zero samples", ADDR_STATUS, 32'h0000_0001);
      fn(MODE_SEND, 8'h00, FN_ACQUIRE, 32'h0000_0002);
      fn(MODE_SEND, 8'h01, 8'h90, 32'h0);
      cap_wait();
      rd_chk("interleaved", ADDR_STATUS, 32'h0013_0000);
      fn(MODE_SEND, 8'h00, FN_FLUSH, 32'h0);
      fn(MODE_SEND, 8'h00, FN_ACQUIRE, 32'h0000_012C);
      cap_wait();
      rd_chk("clamped count", ADDR_STATUS, 32'h0708_0000);
      fn(MODE_SEND, 8'h00, FN_ACQUIRE, 32'h0000_00C8);
      cap_wait();
      rd_chk("full overflow", ADDR_STATUS, 32'h0800_0006);
      fn(MODE_SEND, 8'h00, FN_FLUSH, 32'h0);
      rd_chk("flushed", ADDR_STATUS, 32'h0000_0005);
      wr(ADDR_STATUS, 32'h0000_0004);
      rd_chk("overflow cleared", ADDR_STATUS, 32'h0000_0001);
      $display("test capture done");
      // Store session, errors and replay
      fn(MODE_SEND, 8'h00, FN_STORE_OPEN, 32'h0000_0005);
      rd_chk("bad index high", ADDR_STATUS, 32'h0000_0009);
      wr(ADDR_STATUS, 32'h0000_0008);
      fn(MODE_SEND, 8'h00, FN_STORE_OPEN, 32'h0000_0000);
      rd_chk("bad index low", ADDR_STATUS, 32'h0000_0009);
      wr(ADDR_STATUS, 32'h0000_0008);
      fn(MODE_SEND, 8'h00, FN_STORE_OPEN, 32'h0000_0001);
      fn(MODE_SEND, 8'h02, 8'h11, 32'h0000_0066);
      fn(MODE_SEND, 8'h00, FN_STORE_OPEN, 32'h0000_0004);
      rd_chk("second open", ADDR_STATUS, 32'h0000_0019);
      check("nothing executed", exec_cnt, 16'h0005);
      wr(ADDR_STATUS, 32'h0000_0008);
      fn(MODE_SEND, 8'h00, FN_STORE_CLOSE, 32'h0);
      rd_chk("closed", ADDR_STATUS, 32'h0000_0001);
      fn(MODE_SEND, 8'h00, FN_SW_TRIG, 32'h0000_0001);
      exec_wait(16'h0006);
      check("soft replay", last_pkt, {8'h02, 8'h11, 32'h0000_0066});
      wr(ADDR_TRIG_EN, 32'h0000_0001);
      rd_chk("trig enable", ADDR_TRIG_EN, 32'h0000_0001);
      trig_pin <= 4'h1;
      repeat (4) @(posedge pclk);
      trig_pin <= 4'h0;
      exec_wait(16'h0007);
      check("pin replay", exec_cnt, 16'h0007);
      $display("test store done");
      give_verdict();
   end
endmodule
